// ==== pkg/ienc_pkg.sv ====
// constants and types shared by the incremental encoder evaluation block
package ienc_pkg;
  localparam int CLK_MHZ = 125;
  localparam int STALL_US = 2000;
  localparam int STALL_CYC = STALL_US * CLK_MHZ;
  localparam int WIN_US = 1000;
  localparam int WIN_CYC = WIN_US * CLK_MHZ;
  localparam int MAX_EDGE_KHZ = 150;
  localparam logic [15:0] TC_MAX_US = 16'd32000;
  localparam logic [15:0] TC_RST = 16'h0000;
  localparam logic [13:0] MARKS_MIN = 14'd1;
  localparam logic [13:0] MARKS_MAX = 14'd8192;
  localparam logic [13:0] MARKS_RST = 14'd1024;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MARKS = 8'h04;
  localparam logic [7:0] OFS_FILT = 8'h08;
  localparam logic [7:0] OFS_REACT = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_POS = 8'h18;
  localparam logic [7:0] OFS_SPEED = 8'h1C;
  // status bit positions
  localparam int ST_REF = 0;
  localparam int ST_STALL = 1;
  localparam int ST_DIR = 2;
  localparam int ST_W = 3;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [1:0] REACT_RST = 2'h0;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;
  typedef enum logic [1:0] {
    EVAL_SINGLE = 2'b00,
    EVAL_DOUBLE = 2'b01,
    EVAL_QUAD = 2'b10
  } ienc_eval_type;
endpackage : ienc_pkg

// ==== rtl/ienc_top.sv ====
// incremental encoder evaluation with apb registers and interrupt
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ienc_top
  import ienc_pkg::*;
#(
  parameter int STALL_CYCLES = STALL_CYC,
  parameter int WIN_CYCLES = WIN_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensor tracks
  input wire logic trackA,
  input wire logic trackB,
  input wire logic trackRef,
  // status and fault reaction
  output logic irq,
  output logic dirCw,
  output logic faultTrig,
  output logic [1:0] faultMode
);
  // synchroniser chains: stage 0 only feeds stage 1
  logic [2:0] aSync_q, bSync_q, zSync_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aSync_q <= 3'h0;
      bSync_q <= 3'h0;
      zSync_q <= 3'h0;
    end else begin
      aSync_q <= {aSync_q[1:0], trackA};
      bSync_q <= {bSync_q[1:0], trackB};
      zSync_q <= {zSync_q[1:0], trackRef};
    end
  end

  // edges from stages 1 and 2 only
  logic aRise, aFall, bRise, bFall, zRise;
  assign aRise = aSync_q[1] & ~aSync_q[2];
  assign aFall = ~aSync_q[1] & aSync_q[2];
  assign bRise = bSync_q[1] & ~bSync_q[2];
  assign bFall = ~bSync_q[1] & bSync_q[2];
  assign zRise = zSync_q[1] & ~zSync_q[2];

  // configuration registers
  logic [4:0] ctrl_q;
  logic [13:0] marks_q;
  logic [15:0] filt_q;
  logic [1:0] react_q;
  logic [ST_W-1:0] stat_q, mask_q;
  ienc_eval_type evalSel;
  logic refEn, invDir;
  assign evalSel = ienc_eval_type'(ctrl_q[1:0]);
  assign refEn = ctrl_q[2];
  assign invDir = ctrl_q[3];

  // edge qualification per evaluation level
  logic evalEdge, cwStep;
  always_comb begin
    unique case (evalSel)
      EVAL_SINGLE: begin
        evalEdge = aRise;
        cwStep = ~bSync_q[1];
      end
      EVAL_DOUBLE: begin
        evalEdge = aRise | aFall;
        cwStep = aRise ? ~bSync_q[1] : bSync_q[1];
      end
      EVAL_QUAD: begin
        evalEdge = aRise | aFall | bRise | bFall;
        // B rising while A high follows A rising: clockwise
        cwStep = (aRise & ~bSync_q[1]) | (bRise & aSync_q[1])
          | (aFall & bSync_q[1]) | (bFall & ~aSync_q[1]);
      end
      default: begin
        evalEdge = 1'b0;
        cwStep = 1'b1;
      end
    endcase
  end

  // simultaneous A and B change in quad mode is a skipped state
  logic stepValid, cwEff;
  assign stepValid = evalEdge & ~((aRise | aFall) & (bRise | bFall) & (evalSel == EVAL_QUAD));
  assign cwEff = cwStep ^ invDir;

  // position counter and direction
  logic signed [31:0] pos_q;
  logic dir_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pos_q <= 32'sh0;
      dir_q <= 1'b1;
    end else if (stepValid) begin
      pos_q <= cwEff ? pos_q + 32'sh1 : pos_q - 32'sh1;
      dir_q <= cwEff;
    end
  end
  assign dirCw = dir_q;

  // sequence phase within one A cycle, restarted on A rising
  logic [1:0] seq_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_q <= 2'h0;
    end else if (evalSel == EVAL_QUAD && stepValid) begin
      seq_q <= aRise ? 2'h1 : seq_q + 2'h1;
    end
  end

  // reference check: edges per revolution vs marks times multiplier
  logic [15:0] revCnt_q, revExp;
  logic refArmed_q, refBad;
  always_comb begin
    unique case (evalSel)
      EVAL_DOUBLE: revExp = {1'b0, marks_q, 1'b0};
      EVAL_QUAD: revExp = {marks_q, 2'b00};
      default: revExp = {2'b00, marks_q};
    endcase
  end
  // first rise after enabling only arms: the count before it covers a partial turn
  assign refBad = refEn & zRise & refArmed_q & (revCnt_q != revExp);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      revCnt_q <= 16'h0;
      refArmed_q <= 1'b0;
    end else if (!refEn) begin
      revCnt_q <= 16'h0;
      refArmed_q <= 1'b0;
    end else if (zRise) begin
      // a step in the same cycle belongs to the new revolution
      revCnt_q <= {15'h0, stepValid};
      refArmed_q <= 1'b1;
    end else if (stepValid) begin
      revCnt_q <= revCnt_q + 16'h1;
    end
  end

  // fault reaction pulse with the selected mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      faultTrig <= 1'b0;
    end else begin
      faultTrig <= refBad;
    end
  end
  assign faultMode = react_q;

  // stall watchdog: no evaluated edge for 2 ms
  logic [$clog2(STALL_CYCLES+1)-1:0] stallCnt_q;
  logic stallHit;
  assign stallHit = (stallCnt_q == ($bits(stallCnt_q))'(STALL_CYCLES - 1)) & ~stepValid;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stallCnt_q <= '0;
    end else if (stepValid || stallHit) begin
      stallCnt_q <= '0;
    end else begin
      stallCnt_q <= stallCnt_q + 1'b1;
    end
  end

  // raw speed: signed steps per window
  logic [$clog2(WIN_CYCLES+1)-1:0] winCnt_q;
  logic signed [15:0] acc_q, raw_q;
  logic winEnd;
  assign winEnd = winCnt_q == ($bits(winCnt_q))'(WIN_CYCLES - 1);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      winCnt_q <= '0;
      acc_q <= 16'sh0;
      raw_q <= 16'sh0;
    end else begin
      winCnt_q <= winEnd ? '0 : winCnt_q + 1'b1;
      if (winEnd) begin
        raw_q <= acc_q;
        acc_q <= 16'sh0;
      end else if (stepValid) begin
        acc_q <= cwEff ? acc_q + 16'sh1 : acc_q - 16'sh1;
      end
    end
  end

  // first-order filter, shift grows with tc per window; tc 0 passes through
  logic [2:0] fShift;
  always_comb begin
    fShift = 3'd0;
    for (int k = 0; k < 6; k++) begin
      if (filt_q >= 16'(WIN_US << k)) fShift = 3'(k + 1);
    end
  end
  logic signed [15:0] speed_q;
  logic signed [16:0] fDiff;
  logic winEnd_q;
  assign fDiff = 17'(raw_q) - 17'(speed_q);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      speed_q <= 16'sh0;
      winEnd_q <= 1'b0;
    end else begin
      winEnd_q <= winEnd;
      if (winEnd_q) speed_q <= speed_q + 16'(fDiff >>> fShift);
    end
  end

  // apb decode; slave always ready, unmapped address errors
  logic apbAcc, wrAcc, mapped;
  assign apbAcc = psel & penable;
  assign wrAcc = apbAcc & pwrite;
  assign pready = 1'b1;
  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0;
    unique case (paddr)
      OFS_CTRL: prdata = {27'h0, ctrl_q};
      OFS_MARKS: prdata = {18'h0, marks_q};
      OFS_FILT: prdata = {16'h0, filt_q};
      OFS_REACT: prdata = {30'h0, react_q};
      OFS_STAT: prdata = {29'h0, stat_q};
      OFS_MASK: prdata = {29'h0, mask_q};
      OFS_POS: prdata = pos_q;
      OFS_SPEED: prdata = {{16{speed_q[15]}}, speed_q};
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = apbAcc & ~mapped;

  // configuration writes; out-of-range values are clamped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
      marks_q <= MARKS_RST;
      filt_q <= TC_RST;
      react_q <= REACT_RST;
      mask_q <= MASK_RST;
    end else if (wrAcc) begin
      unique case (paddr)
        OFS_CTRL: ctrl_q <= (pwdata[1:0] == 2'b11) ? {pwdata[4:2], 2'b10} : pwdata[4:0];
        OFS_MARKS: begin
          if (pwdata[31:0] > 32'(MARKS_MAX)) marks_q <= MARKS_MAX;
          else if (pwdata[13:0] < MARKS_MIN) marks_q <= MARKS_MIN;
          else marks_q <= pwdata[13:0];
        end
        OFS_FILT: filt_q <= (pwdata > 32'(TC_MAX_US)) ? TC_MAX_US : pwdata[15:0];
        OFS_REACT: react_q <= pwdata[1:0];
        OFS_MASK: mask_q <= pwdata[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky status, write one to clear, a new event wins over the clear
  logic [ST_W-1:0] evt, clr;
  assign evt = {stepValid & (cwEff != dir_q), stallHit, refBad};
  assign clr = (wrAcc && paddr == OFS_STAT) ? pwdata[ST_W-1:0] : '0;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | evt;
    end
  end
  assign irq = |(stat_q & mask_q);

  // checks: counting per evaluation level
  // disable iff keeps every check quiet while reset is low
  a_pos_up: assert property (@(posedge clk) disable iff (!nrst)
    stepValid && cwEff |=> pos_q == $past(pos_q) + 32'sh1) else $error("position did not count up");
  a_pos_down: assert property (@(posedge clk) disable iff (!nrst)
    stepValid && !cwEff |=> pos_q == $past(pos_q) - 32'sh1) else $error("position did not count down");
  a_single_edges: assert property (@(posedge clk) disable iff (!nrst)
    evalSel == EVAL_SINGLE && !aRise |=> $stable(pos_q)) else $error("single mode counted a non A-rise");
  a_single_rise: assert property (@(posedge clk) disable iff (!nrst)
    evalSel == EVAL_SINGLE && aRise |=> pos_q != $past(pos_q)) else $error("single mode missed A rise");
  a_double_fall: assert property (@(posedge clk) disable iff (!nrst)
    evalSel == EVAL_DOUBLE && aFall |=> pos_q != $past(pos_q)) else $error("double mode missed A fall");
  a_double_rise: assert property (@(posedge clk) disable iff (!nrst)
    evalSel == EVAL_DOUBLE && aRise |=> pos_q != $past(pos_q)) else $error("double mode missed A rise");
  a_track_b_ignored: assert property (@(posedge clk) disable iff (!nrst)
    evalSel != EVAL_QUAD && !aRise && !aFall |=> $stable(pos_q)) else $error("B edge counted outside quad mode");
  a_quad_bedge: assert property (@(posedge clk) disable iff (!nrst)
    evalSel == EVAL_QUAD && bRise && !aRise && !aFall |=> pos_q != $past(pos_q)) else $error("quad missed B edge");
  a_cw_order: assert property (@(posedge clk) disable iff (!nrst)
    evalSel == EVAL_QUAD && !invDir && bRise && aSync_q[1] && !aRise && !aFall |=> dir_q)
    else $error("A then B rise not cw");
  a_acw_order: assert property (@(posedge clk) disable iff (!nrst)
    evalSel == EVAL_QUAD && !invDir && bFall && aSync_q[1] && !aRise && !aFall |=> !dir_q)
    else $error("A rise, B fall not acw");
  // sequence within one A cycle
  a_seq_restart: assert property (@(posedge clk) disable iff (!nrst)
    evalSel == EVAL_QUAD && aRise && !bRise && !bFall |=> seq_q == 2'h1) else $error("sequence not restarted");
  a_seq_advance: assert property (@(posedge clk) disable iff (!nrst)
    evalSel == EVAL_QUAD && stepValid && !aRise |=> seq_q == $past(seq_q) + 2'h1) else $error("sequence stuck");
  // edge capture; one edge per three cycles is well past 150 kHz
  a_sync_delay: assert property (@(posedge clk) disable iff (!nrst)
    aRise |-> $past(trackA, 2) && !$past(trackA, 3)) else $error("A edge not two stages late");
  a_a_capture: assert property (@(posedge clk) disable iff (!nrst)
    aSync_q[0] && !aSync_q[1] |=> aRise) else $error("A change not seen as edge");
  a_b_capture: assert property (@(posedge clk) disable iff (!nrst)
    bSync_q[0] != bSync_q[1] |=> bRise || bFall) else $error("B change not seen as edge");
  // reference check and fault reaction
  a_ref_arm: assert property (@(posedge clk) disable iff (!nrst)
    refEn && zRise |=> refArmed_q) else $error("reference check not armed");
  a_ref_count: assert property (@(posedge clk) disable iff (!nrst)
    refEn && zRise |=> revCnt_q == {15'h0, $past(stepValid)}) else $error("revolution count not restarted");
  a_ref_ok: assert property (@(posedge clk) disable iff (!nrst)
    zRise && revCnt_q == revExp |=> !faultTrig) else $error("fault on good revolution");
  a_ref_off: assert property (@(posedge clk) disable iff (!nrst)
    !refEn |=> !faultTrig) else $error("fault with reference check off");
  a_ref_fault: assert property (@(posedge clk) disable iff (!nrst)
    refBad |=> faultTrig && stat_q[ST_REF]) else $error("reference fault not raised");
  a_fault_pulse: assert property (@(posedge clk) disable iff (!nrst)
    faultTrig |=> !faultTrig) else $error("fault trigger longer than one cycle");
  // stall, filter, configuration and status
  a_stall_flag: assert property (@(posedge clk) disable iff (!nrst)
    stallHit |=> stat_q[ST_STALL] && stallCnt_q == '0) else $error("stall not flagged");
  a_stall_restart: assert property (@(posedge clk) disable iff (!nrst)
    stepValid |=> stallCnt_q == '0) else $error("stall count not restarted");
  a_no_filter: assert property (@(posedge clk) disable iff (!nrst)
    filt_q < 16'(WIN_US) && winEnd_q |=> speed_q == $past(raw_q)) else $error("unfiltered speed differs");
  a_marks_range: assert property (@(posedge clk) disable iff (!nrst)
    marks_q >= MARKS_MIN && marks_q <= MARKS_MAX) else $error("division marks out of range");
  a_dir_status: assert property (@(posedge clk) disable iff (!nrst)
    stepValid && cwEff != dir_q |=> stat_q[ST_DIR]) else $error("direction change not flagged");
  a_stat_sticky: assert property (@(posedge clk) disable iff (!nrst)
    stat_q[ST_REF] && !clr[ST_REF] |=> stat_q[ST_REF]) else $error("reference status lost");
  a_bad_addr: assert property (@(posedge clk) disable iff (!nrst)
    apbAcc && paddr > OFS_SPEED |-> pslverr) else $error("unmapped access not refused");
  c_quad_cycle: cover property (@(posedge clk) disable iff (!nrst) evalSel == EVAL_QUAD && seq_q == 2'h3 ##[1:1000] aRise);
  c_ref_bad: cover property (@(posedge clk) disable iff (!nrst) refBad);
  c_ref_good: cover property (@(posedge clk) disable iff (!nrst) refEn && zRise && refArmed_q && !refBad);
  c_stall: cover property (@(posedge clk) disable iff (!nrst) stallHit);
  c_dir_change: cover property (@(posedge clk) disable iff (!nrst) stepValid && cwEff != dir_q);
endmodule : ienc_top
`default_nettype wire

// ==== verif/ienc_sensor_model.sv ====
// behavioural quadrature sensor with reference track
`timescale 1ns/1ns
`default_nettype none
module ienc_sensor_model (
  // clock
  input wire logic clk,
  // tracks
  output logic trackA,
  output logic trackB,
  output logic trackRef
);
  int phase = 0;
  int edgeCnt = 0;
  int perRev = 8;
  initial trackRef = 1'b0;
  // gray phase to levels, A leads B when turning clockwise
  always_comb begin
    trackA = (phase == 1) || (phase == 2);
    trackB = (phase == 2) || (phase == 3);
  end
  // six cycles a step keeps edges well apart for the synchroniser
  task automatic move(input int n, input bit cw);
    repeat (n) begin
      @(posedge clk);
      phase <= cw ? (phase + 1) % 4 : (phase + 3) % 4;
      edgeCnt++;
      repeat (2) @(posedge clk);
      if (edgeCnt >= perRev) begin
        trackRef <= 1'b1;
        edgeCnt = 0;
      end
      repeat (3) @(posedge clk);
      trackRef <= 1'b0;
    end
  endtask : move
endmodule : ienc_sensor_model
`default_nettype wire

// ==== verif/test_incremental_encoder_evaluation.sv ====
// self-checking bench for the incremental encoder block
`timescale 1ns/1ns
`default_nettype none
module test_incremental_encoder_evaluation import ienc_pkg::*;;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, dirCw, faultTrig;
  logic trackA, trackB, trackRef;
  logic [1:0] faultMode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, expPos, react;
  logic [63:0] note;
  logic [63:0] notes[$];
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int faultCnt = 0;
  int mult[4] = '{1, 2, 4, -4};
  logic [31:0] modes[4] = '{32'h0, 32'h1, 32'h2, 32'hA};

  // short counts so stall and speed windows fit the run
  ienc_top #(.STALL_CYCLES(200), .WIN_CYCLES(100)) i_ienc_top (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trackA(trackA), .trackB(trackB), .trackRef(trackRef), .irq(irq), .dirCw(dirCw),
    .faultTrig(faultTrig), .faultMode(faultMode));
  ienc_sensor_model i_ienc_sensor_model (.clk(clk), .trackA(trackA), .trackB(trackB), .trackRef(trackRef));

  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end
  // fault pulses
  always @(posedge clk) if (faultTrig === 1'b1) faultCnt++;

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (exp !== got) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // every completion checks its error flag, reads take the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      check("pslverr", {31'h0, paddr > 8'h1C}, {31'h0, pslverr});
      if (!pwrite) begin
        note = notes.pop_front();
        check("prdata", note[31:0], prdata & note[63:32]);
      end
    end
  end

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  // expected value noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({m, e & m});
    apb(a, 1'b0, 32'h0);
  endtask : rd
  task automatic move(input int n, input bit cw);
    i_ienc_sensor_model.move(n, cw);
  endtask : move

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // main sequence
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    react = $urandom(47);
    react = $urandom & 32'h3;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(OFS_CTRL, 32'h0, ALL);
    rd(OFS_MARKS, 32'd1024, ALL);
    rd(OFS_FILT, 32'h0, ALL);
    rd(OFS_MASK, 32'h0, ALL);
    wr(8'h20, ALL);
    rd(8'h20, 32'h0, ALL);
    wr(OFS_MARKS, 32'h0);
    rd(OFS_MARKS, 32'd1, ALL);
    wr(OFS_MARKS, 32'd9000);
    rd(OFS_MARKS, 32'd8192, ALL);
    wr(OFS_FILT, 32'd40000);
    rd(OFS_FILT, 32'd32000, ALL);
    wr(OFS_CTRL, 32'h3);
    rd(OFS_CTRL, 32'h2, ALL);
    wr(OFS_MARKS, 32'd1024);
    // each evaluation level, both directions, last one inverted
    expPos = 32'h0;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, modes[i]);
      move(8, 1'b1);
      expPos = expPos + 32'(2 * mult[i]);
      rd(OFS_POS, expPos, ALL);
      @(negedge clk);
      check("dirCw", {31'h0, i != 3}, {31'h0, dirCw});
      move(4, 1'b0);
      expPos = expPos - 32'(mult[i]);
      rd(OFS_POS, expPos, ALL);
      @(negedge clk);
      check("dirCw", {31'h0, i == 3}, {31'h0, dirCw});
    end
    rd(OFS_MARKS, 32'd1024, ALL);
    // direction change, then stall with interrupt
    wr(OFS_CTRL, 32'h2);
    wr(OFS_STAT, 32'h7);
    move(4, 1'b0);
    rd(OFS_STAT, 32'h4, 32'h4);
    wr(OFS_STAT, 32'h7);
    rd(OFS_STAT, 32'h0, 32'h7);
    repeat (250) @(posedge clk);
    rd(OFS_STAT, 32'h2, 32'h7);
    wr(OFS_MASK, 32'h2);
    @(negedge clk);
    check("irq", 32'h1, {31'h0, irq});
    wr(OFS_STAT, 32'h2);
    @(negedge clk);
    check("irq", 32'h0, {31'h0, irq});
    // reference spacing with one wrong revolution
    wr(OFS_MARKS, 32'd2);
    wr(OFS_REACT, react);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CTRL, 32'h6);
    i_ienc_sensor_model.edgeCnt = 0;
    move(24, 1'b1);
    repeat (2) @(posedge clk);
    check("faultCnt", 32'h0, 32'(faultCnt));
    rd(OFS_STAT, 32'h0, 32'h1);
    i_ienc_sensor_model.perRev = 9;
    move(9, 1'b1);
    i_ienc_sensor_model.perRev = 8;
    move(8, 1'b1);
    repeat (2) @(posedge clk);
    check("faultCnt", 32'h1, 32'(faultCnt));
    rd(OFS_STAT, 32'h1, 32'h1);
    @(negedge clk);
    check("irq", 32'h1, {31'h0, irq});
    check("faultMode", react, {30'h0, faultMode});
    results();
  end
endmodule : test_incremental_encoder_evaluation
`default_nettype wire
